// file: hdl/amr_pkg.sv
// Constants, types and helpers for the asynchronous multiplexer receive path
package amr_pkg;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int NUM_LINES     = 16;
  localparam int SILO_DEPTH    = 64;  // 128-deep option: raise to 128 and widen fill to 8 bits
  localparam logic [3:0] OVS_LAST  = 4'hF;  // 16 sample clocks per bit
  localparam logic [3:0] HALF_LAST = 4'h7;  // eighth sample clock
  localparam int CLK_MHZ       = 20;
  localparam int SELF_TEST_US  = 100;
  localparam logic [11:0] SELF_TEST_CYC = 12'(SELF_TEST_US * CLK_MHZ);

  // ----------------------------------------------------------------------
  // Register offsets (byte) and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_SCR = 4'h0;
  localparam logic [3:0] OFS_RCR = 4'h2;
  localparam logic [3:0] OFS_LPR = 4'h4;
  localparam logic [3:0] OFS_SSR = 4'hE;
  localparam int SCR_RIE_BIT = 7;
  localparam int SCR_RI_BIT  = 8;
  localparam int SCR_NXM_BIT = 11;
  localparam int SCR_MC_BIT  = 12;
  localparam int RCR_VDP_BIT = 15;
  localparam int RCR_OVR_BIT = 14;
  localparam int RCR_FE_BIT  = 13;
  localparam int RCR_PE_BIT  = 12;
  localparam int LPR_TSB_BIT = 2;
  localparam int LPR_PEN_BIT = 4;
  localparam int LPR_ODD_BIT = 5;
  localparam int LPR_HD_BIT  = 14;
  localparam logic [15:0] LPR_RESET = 16'h0003;
  localparam logic [7:0]  THR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Base address tables
  // ----------------------------------------------------------------------
  localparam logic [21:0] MUX_BASE0   = 22'h3F_E010;
  localparam logic [21:0] MUX_STEP    = 22'h00_0010;
  localparam logic [21:0] MODEM_BASE0 = 22'h3F_F140;
  localparam logic [21:0] MODEM_STEP  = 22'h00_0008;
  localparam logic [3:0]  SW_MAX      = 4'hB;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } amr_rx_st_t;

  typedef enum logic {
    DMA_IDLE = 1'b0,
    DMA_BUSY = 1'b1
  } amr_dma_st_t;

  typedef struct packed {
    amr_rx_st_t  st;
    logic        armed;
    logic [3:0]  cnt;
    logic [3:0]  nbit;
    logic [7:0]  sh;
    logic        pbit;
    logic [15:0] lpr;
    logic [15:0] hold;
  } amr_line_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] amr_char_bits(input logic [15:0] lpr);
    return 4'd5 + {2'b00, lpr[1:0]};
  endfunction

  function automatic logic [21:0] amr_base(input logic [3:0] sel,
                                           input logic [21:0] base0,
                                           input logic [21:0] step);
    logic [3:0] s;
    s = (sel > SW_MAX) ? SW_MAX : sel;
    return 22'(base0 + 22'(s) * step);
  endfunction

endpackage

// file: hdl/amr_receive_path.sv
// Receive path: line receivers, scanner, staging buffer, silo, registers
`timescale 1ns/1ps
module amr_receive_path
  import amr_pkg::*;
(
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_B,
  input  wire logic                 DC_POWER_GOOD,
  input  wire logic                 BUS_INIT,
  input  wire logic [3:0]           BASE_ADDRESS_SWITCH,
  input  wire logic [NUM_LINES-1:0] RX_SERIAL,
  input  wire logic [NUM_LINES-1:0] RX_SAMPLE_TICK,
  input  wire logic [NUM_LINES-1:0] TX_BUFFER_ACTIVE,
  input  wire logic [3:0]           REG_ADDR,
  input  wire logic                 REG_RD,
  input  wire logic                 REG_WR,
  input  wire logic [15:0]          REG_WDATA,
  input  wire logic                 TX_DMA_REQ,
  input  wire logic [21:0]          TX_DMA_ADDR,
  input  wire logic                 DMA_DONE,
  input  wire logic [17:0]          DMA_DATA,
  output logic [15:0]               REG_RDATA,
  output logic                      IRQ_BR5,
  output logic                      NONEXISTENT_MEMORY_ERROR,
  output logic                      SELF_TEST_BUSY,
  output logic [21:0]               MUX_BASE_ADDR,
  output logic [21:0]               MODEM_BASE_ADDR,
  output logic                      DMA_RD_STB,
  output logic                      DMA_WORD,
  output logic [21:0]               DMA_ADDR,
  output logic                      TX_DMA_ACK,
  output logic [15:0]               TX_DMA_DATA
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    amr_line_t [NUM_LINES-1:0]  line;
    logic [3:0]                 scan;
    logic [1:0][15:0]           buf_q;
    logic [1:0]                 buf_cnt;
    logic [SILO_DEPTH-1:0][15:0] silo;
    logic [6:0]                 fill;
    logic [7:0]                 thr;
    logic [3:0]                 sel_line;
    logic                       rie;
    logic                       nonexistent_memory_error;
    logic [11:0]                st_cnt;
    amr_dma_st_t                dma_st;
    logic [15:0]                rdata;
    logic                       irq;
    logic                       st_busy;
    logic [21:0]                mux_base;
    logic [21:0]                modem_base;
    logic                       dma_stb;
    logic                       dma_word;
    logic [21:0]                dma_addr;
    logic                       tx_ack;
    logic [15:0]                tx_data;
  } amr_state_t;

  amr_state_t state_ff;
  amr_state_t nxt_state;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    amr_state_t n;
    logic       clr;
    logic       hold_any;
    logic       buf_pop;
    logic       buf_push;
    logic [15:0] push_word;
    logic       silo_pop;
    logic       rxd;
    logic       tick;
    logic [3:0] nbits;
    logic [3:0] total;
    logic [7:0] chr;
    logic       perr;
    n         = state_ff;
    clr       = 1'b0;
    hold_any  = 1'b0;
    buf_pop   = 1'b0;
    buf_push  = 1'b0;
    push_word = 16'h0000;
    silo_pop  = 1'b0;
    rxd       = 1'b1;
    tick      = 1'b0;
    nbits     = 4'h0;
    total     = 4'h0;
    chr       = 8'h00;
    perr      = 1'b0;

    // Base addresses follow the switch continuously
    n.mux_base   = amr_base(BASE_ADDRESS_SWITCH, MUX_BASE0, MUX_STEP);
    n.modem_base = amr_base(BASE_ADDRESS_SWITCH, MODEM_BASE0, MODEM_STEP);
    n.tx_ack     = 1'b0;
    n.dma_word   = 1'b1;  // Never byte reads

    // --------------------------------------------------------------------
    // Scanner: one line per cycle into the staging buffer
    // --------------------------------------------------------------------
    for (int i = 0; i < NUM_LINES; i++)
    begin
      hold_any = hold_any | state_ff.line[i].hold[RCR_VDP_BIT];
    end
    if (state_ff.line[state_ff.scan].hold[RCR_VDP_BIT] &&
        state_ff.buf_cnt != 2'd2)
    begin
      buf_push  = 1'b1;
      push_word = state_ff.line[state_ff.scan].hold;
      n.line[state_ff.scan].hold[RCR_VDP_BIT] = 1'b0;
    end
    n.scan = 4'(state_ff.scan + 4'h1);

    // --------------------------------------------------------------------
    // Line receivers
    // --------------------------------------------------------------------
    for (int i = 0; i < NUM_LINES; i++)
    begin
      rxd   = RX_SERIAL[i];
      tick  = RX_SAMPLE_TICK[i];
      nbits = amr_char_bits(state_ff.line[i].lpr);
      total = 4'(nbits + {3'b000, state_ff.line[i].lpr[LPR_PEN_BIT]});
      if (state_ff.line[i].lpr[LPR_HD_BIT] && TX_BUFFER_ACTIVE[i])
      begin
        // Blinded while own transmitter drives the shared circuit
        n.line[i].st    = RX_IDLE;
        n.line[i].armed = 1'b0;
      end
      else if (tick)
      begin
        case (state_ff.line[i].st)
          RX_IDLE:
          begin
            n.line[i].armed = rxd;
            if (state_ff.line[i].armed && !rxd)
            begin
              n.line[i].st  = RX_START;
              n.line[i].cnt = 4'h0;
            end
          end
          RX_START:
          begin
            n.line[i].cnt = 4'(state_ff.line[i].cnt + 4'h1);
            if (state_ff.line[i].cnt == HALF_LAST)
            begin
              n.line[i].cnt  = 4'h0;
              n.line[i].nbit = 4'h0;
              n.line[i].st   = rxd ? RX_IDLE : RX_DATA;
              n.line[i].armed = rxd;
            end
          end
          RX_DATA:
          begin
            n.line[i].cnt = 4'(state_ff.line[i].cnt + 4'h1);
            if (state_ff.line[i].cnt == OVS_LAST)
            begin
              n.line[i].nbit = 4'(state_ff.line[i].nbit + 4'h1);
              if (state_ff.line[i].nbit < nbits)
                n.line[i].sh = {rxd, state_ff.line[i].sh[7:1]};
              else
                n.line[i].pbit = rxd;
              if (state_ff.line[i].nbit == 4'(total - 4'h1))
                n.line[i].st = RX_STOP;
            end
          end
          RX_STOP:
          begin
            n.line[i].cnt = 4'(state_ff.line[i].cnt + 4'h1);
            if (state_ff.line[i].cnt == OVS_LAST)
            begin
              // Only the first stop bit is checked; TSB matters to transmit
              chr  = state_ff.line[i].sh >> (4'd8 - nbits);
              perr = state_ff.line[i].lpr[LPR_PEN_BIT] &&
                     ((^chr ^ state_ff.line[i].pbit) !=
                      state_ff.line[i].lpr[LPR_ODD_BIT]);
              n.line[i].hold = 16'h0000;
              n.line[i].hold[RCR_VDP_BIT] = 1'b1;
              n.line[i].hold[RCR_OVR_BIT] = n.line[i].hold[RCR_VDP_BIT] &
                                            state_ff.line[i].hold[RCR_VDP_BIT]
                                            & ~(buf_push &&
                                                state_ff.scan == 4'(i));
              n.line[i].hold[RCR_FE_BIT]  = ~rxd;
              n.line[i].hold[RCR_PE_BIT]  = perr;
              n.line[i].hold[11:8]        = 4'(i);
              n.line[i].hold[7:0]         = chr;
              n.line[i].st    = RX_IDLE;
              n.line[i].armed = rxd;
            end
          end
          default:
            n.line[i].st = RX_IDLE;
        endcase
      end
    end

    // --------------------------------------------------------------------
    // Staging buffer to silo
    // --------------------------------------------------------------------
    silo_pop = REG_RD && REG_ADDR == OFS_RCR && state_ff.fill != 7'd0;
    buf_pop  = state_ff.buf_cnt != 2'd0 &&
               state_ff.fill != 7'(SILO_DEPTH);
    if (silo_pop)
    begin
      for (int k = 0; k < SILO_DEPTH - 1; k++)
        n.silo[k] = state_ff.silo[k+1];
      n.silo[SILO_DEPTH-1] = 16'h0000;
    end
    n.fill = 7'(state_ff.fill - {6'h00, silo_pop});
    if (buf_pop)
    begin
      n.silo[n.fill] = state_ff.buf_q[0];
      n.fill         = 7'(n.fill + 7'd1);
      n.buf_q[0]     = state_ff.buf_q[1];
    end
    n.buf_cnt = 2'(state_ff.buf_cnt - {1'b0, buf_pop});
    if (buf_push)
    begin
      n.buf_q[n.buf_cnt[0]] = push_word;
      n.buf_cnt = 2'(n.buf_cnt + 2'd1);
    end

    // --------------------------------------------------------------------
    // Register access
    // --------------------------------------------------------------------
    if (REG_RD)
    begin
      case (REG_ADDR)
        OFS_SCR:
        begin
          n.rdata = 16'h0000;
          n.rdata[3:0]         = state_ff.sel_line;
          n.rdata[SCR_RIE_BIT] = state_ff.rie;
          n.rdata[SCR_RI_BIT]  = state_ff.irq;
          n.rdata[SCR_NXM_BIT] = state_ff.nonexistent_memory_error;
        end
        OFS_RCR: n.rdata = (state_ff.fill != 7'd0) ? state_ff.silo[0]
                                                   : 16'h0000;
        OFS_LPR: n.rdata = state_ff.line[state_ff.sel_line].lpr;
        OFS_SSR: n.rdata = {1'b0, state_ff.fill, state_ff.thr};
        default: n.rdata = 16'h0000;
      endcase
    end
    if (REG_WR)
    begin
      case (REG_ADDR)
        OFS_SCR:
        begin
          n.sel_line = REG_WDATA[3:0];
          n.rie      = REG_WDATA[SCR_RIE_BIT];
          n.nonexistent_memory_error      = state_ff.nonexistent_memory_error & REG_WDATA[SCR_NXM_BIT];
          clr        = REG_WDATA[SCR_MC_BIT];
        end
        OFS_LPR: n.line[state_ff.sel_line].lpr = REG_WDATA;
        OFS_SSR: n.thr = REG_WDATA[7:0];
        default: n.thr = n.thr;
      endcase
    end

    // --------------------------------------------------------------------
    // Transmit DMA reads, deferred to receive traffic
    // --------------------------------------------------------------------
    case (state_ff.dma_st)
      DMA_IDLE:
      begin
        if (TX_DMA_REQ && !hold_any && state_ff.buf_cnt == 2'd0)
        begin
          n.dma_st   = DMA_BUSY;
          n.dma_stb  = 1'b1;
          n.dma_addr = {TX_DMA_ADDR[21:1], 1'b0};
        end
      end
      DMA_BUSY:
      begin
        if (DMA_DONE)
        begin
          n.dma_st  = DMA_IDLE;
          n.dma_stb = 1'b0;
          n.tx_ack  = 1'b1;
          n.tx_data = DMA_DATA[15:0];
          // Lines 17:16 hold parity status in the data phase
          if (DMA_DATA[17] && DMA_DATA[16])
            n.nonexistent_memory_error = 1'b1;
        end
      end
      default: n.dma_st = DMA_IDLE;
    endcase

    // Interrupt at bus level five once the threshold is reached
    n.irq = state_ff.rie && state_ff.fill != 7'd0 &&
            {1'b0, state_ff.fill} >= state_ff.thr;

    // --------------------------------------------------------------------
    // Self-test and clears
    // --------------------------------------------------------------------
    if (state_ff.st_cnt != 12'h000)
      n.st_cnt = 12'(state_ff.st_cnt - 12'h001);
    n.st_busy = n.st_cnt != 12'h000;
    clr = clr || !DC_POWER_GOOD || BUS_INIT || state_ff.st_busy;
    if (clr || !RST_B)
    begin
      for (int i = 0; i < NUM_LINES; i++)
      begin
        n.line[i]     = '0;
        n.line[i].lpr = LPR_RESET;
      end
      n.scan     = 4'h0;
      n.buf_q    = '0;
      n.buf_cnt  = 2'd0;
      n.silo     = '0;
      n.fill     = 7'd0;
      n.thr      = THR_RESET;
      n.sel_line = 4'h0;
      n.rie      = 1'b0;
      n.nonexistent_memory_error      = 1'b0;
      n.dma_st   = DMA_IDLE;
      n.dma_stb  = 1'b0;
      n.dma_addr = 22'h00_0000;
      n.tx_ack   = 1'b0;
      n.tx_data  = 16'h0000;
      n.irq      = 1'b0;
      n.rdata    = 16'h0000;
    end
    if (!RST_B)
    begin
      // Only a power-up reset starts the self-test, never a clear
      n.st_cnt     = SELF_TEST_CYC;
      n.st_busy    = 1'b1;
      n.mux_base   = 22'h00_0000;
      n.modem_base = 22'h00_0000;
      n.dma_word   = 1'b1;
    end
    nxt_state = n;
  end

  always_ff @(posedge REF_CLK)
  begin
    state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA                = state_ff.rdata;
  assign IRQ_BR5                  = state_ff.irq;
  assign NONEXISTENT_MEMORY_ERROR = state_ff.nonexistent_memory_error;
  assign SELF_TEST_BUSY           = state_ff.st_busy;
  assign MUX_BASE_ADDR            = state_ff.mux_base;
  assign MODEM_BASE_ADDR          = state_ff.modem_base;
  assign DMA_RD_STB               = state_ff.dma_stb;
  assign DMA_WORD                 = state_ff.dma_word;
  assign DMA_ADDR                 = state_ff.dma_addr;
  assign TX_DMA_ACK               = state_ff.tx_ack;
  assign TX_DMA_DATA              = state_ff.tx_data;

endmodule // amr_receive_path

// file: verif/amr_mem_model.sv
// Host memory model answering word reads
`timescale 1ns/1ps
module amr_mem_model
(
  input wire logic        clk,
  input wire logic [21:0] addr,
  input wire logic        stb,
  output logic            done,
  output logic [17:0]     data
);
  logic [17:0] d;
  // Address bit 2 asks for a slow answer, bit 4 for a parity fault
  initial
  begin
    done = 1'b0;
    data = 18'h2_AAAA;
    forever
    begin
      @(posedge clk);
      if (stb === 1'b1)
      begin
        repeat (addr[2] ? 4 : 0) @(posedge clk);
        d = {addr[4] ? 2'b11 : 2'b00, addr[16:1] ^ 16'hC3A5};
        done <= 1'b1;
        data <= d;
        @(posedge clk);
        done <= 1'b0;
        // Released bus shows garbage, not the last word
        data <= ~d;
      end
    end
  end
endmodule // amr_mem_model

// file: verif/amr_receive_path_assertions.sv
// Port-level checker for the receive path top module
`timescale 1ns/1ps
module amr_receive_path_assertions
  import amr_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        DC_POWER_GOOD,
  input wire logic        BUS_INIT,
  input wire logic [3:0]  BASE_ADDRESS_SWITCH,
  input wire logic [21:0] TX_DMA_ADDR,
  input wire logic        DMA_DONE,
  input wire logic [17:0] DMA_DATA,
  input wire logic        IRQ_BR5,
  input wire logic        NONEXISTENT_MEMORY_ERROR,
  input wire logic        SELF_TEST_BUSY,
  input wire logic [21:0] MUX_BASE_ADDR,
  input wire logic [21:0] MODEM_BASE_ADDR,
  input wire logic        DMA_RD_STB,
  input wire logic        DMA_WORD,
  input wire logic [21:0] DMA_ADDR,
  input wire logic        TX_DMA_ACK,
  input wire logic [15:0] TX_DMA_DATA
);
  logic [3:0] sw_clip;
  logic       clr;
  // Switch settings past the table act as its last entry
  always_comb sw_clip = (BASE_ADDRESS_SWITCH > SW_MAX) ? SW_MAX
                                                       : BASE_ADDRESS_SWITCH;
  always_comb clr = BUS_INIT || !DC_POWER_GOOD;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  property p_word;
    DMA_WORD;
  endproperty
  a_word: assert property (p_word) else $error("byte dma read");
  property p_stb_hold;
    DMA_RD_STB && !DMA_DONE |=> DMA_RD_STB;
  endproperty
  a_stb_hold: assert property (p_stb_hold)
    else $error("read strobe dropped early");
  property p_ack;
    DMA_RD_STB && DMA_DONE |=> !DMA_RD_STB && TX_DMA_ACK
      && TX_DMA_DATA == $past(DMA_DATA[15:0]);
  endproperty
  a_ack: assert property (p_ack) else $error("dma answer wrong");
  property p_addr;
    $rose(DMA_RD_STB) |-> DMA_ADDR == {$past(TX_DMA_ADDR[21:1]), 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("dma address wrong");
  property p_nxm;
    DMA_RD_STB && DMA_DONE && DMA_DATA[17:16] == 2'b11 && !clr
      |=> NONEXISTENT_MEMORY_ERROR;
  endproperty
  a_nxm: assert property (p_nxm) else $error("parity not flagged");
  property p_nxm_quiet;
    !NONEXISTENT_MEMORY_ERROR && !(DMA_DONE && DMA_DATA[17:16] == 2'b11)
      |=> !NONEXISTENT_MEMORY_ERROR;
  endproperty
  a_nxm_quiet: assert property (p_nxm_quiet)
    else $error("memory error without cause");
  property p_clear;
    clr |=> !IRQ_BR5 && !NONEXISTENT_MEMORY_ERROR && !DMA_RD_STB;
  endproperty
  a_clear: assert property (p_clear) else $error("clear incomplete");
  property p_no_retest;
    !SELF_TEST_BUSY |=> !SELF_TEST_BUSY;
  endproperty
  a_no_retest: assert property (p_no_retest)
    else $error("self-test restarted");
  property p_mux;
    $past(RST_B) && !$past(clr)
      |-> MUX_BASE_ADDR == 22'(MUX_BASE0 + MUX_STEP * $past(sw_clip));
  endproperty
  a_mux: assert property (p_mux) else $error("mux base wrong");
  property p_modem;
    $past(RST_B) && !$past(clr)
      |-> MODEM_BASE_ADDR == 22'(MODEM_BASE0 + MODEM_STEP * $past(sw_clip));
  endproperty
  a_modem: assert property (p_modem) else $error("modem base wrong");

  c_ack: cover property (TX_DMA_ACK);
  c_nxm: cover property ($rose(NONEXISTENT_MEMORY_ERROR));
  c_irq: cover property ($rose(IRQ_BR5));
endmodule // amr_receive_path_assertions

// file: verif/amr_receive_path_tb.sv
// Self-checking testbench for the receive path
`timescale 1ns/1ps
module amr_receive_path_tb
  import amr_pkg::*;
;
  typedef struct packed {
    logic [3:0]  line;
    logic [15:0] lpr;
    logic [7:0]  data;
    logic        par;
    logic        stop;
    logic [15:0] exp;
  } amr_row_t;
  logic        ref_clk, rst_b, pwr_good, bus_init, reg_rd, reg_wr, dma_req;
  logic        dma_done, irq, nonexistent_memory_error, st_busy, dma_stb, dma_word, dma_ack;
  logic [3:0]  sw, reg_addr;
  logic [15:0] rx_ser, tx_active, wdata, rdata, dma_rdata, v, ticks;
  logic [17:0] dma_data;
  logic [21:0] dma_req_addr, mux_base, modem_base, dma_addr;
  int          n_errors, n_compared;
  amr_row_t    rows [4] = '{
    '{4'h0, 16'h0003, 8'hA5, 1'b0, 1'b1, 16'h80A5},
    '{4'h3, 16'h0010, 8'h13, 1'b1, 1'b1, 16'h8313},
    '{4'h7, 16'h0032, 8'h55, 1'b0, 1'b1, 16'h9755},
    '{4'hF, 16'h0001, 8'h2A, 1'b0, 1'b0, 16'hAF2A}};

  amr_receive_path amr_receive_path_inst (.REF_CLK(ref_clk), .RST_B(rst_b),
    .DC_POWER_GOOD(pwr_good), .BUS_INIT(bus_init),
    .BASE_ADDRESS_SWITCH(sw), .RX_SERIAL(rx_ser),
    .RX_SAMPLE_TICK(ticks), .TX_BUFFER_ACTIVE(tx_active),
    .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_WR(reg_wr),
    .REG_WDATA(wdata), .TX_DMA_REQ(dma_req), .TX_DMA_ADDR(dma_req_addr),
    .DMA_DONE(dma_done), .DMA_DATA(dma_data), .REG_RDATA(rdata),
    .IRQ_BR5(irq), .NONEXISTENT_MEMORY_ERROR(nonexistent_memory_error),
    .SELF_TEST_BUSY(st_busy), .MUX_BASE_ADDR(mux_base),
    .MODEM_BASE_ADDR(modem_base), .DMA_RD_STB(dma_stb),
    .DMA_WORD(dma_word), .DMA_ADDR(dma_addr), .TX_DMA_ACK(dma_ack),
    .TX_DMA_DATA(dma_rdata));
  amr_mem_model amr_mem_model_inst (.clk(ref_clk), .addr(dma_addr),
    .stb(dma_stb), .done(dma_done), .data(dma_data));

  // ----------------------------------------------------------------------
  // Bus and line tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk({6'h00, rdata}, {6'h00, e});
  endtask
  task automatic bitout(input logic [3:0] ln, input logic b);
    @(negedge ref_clk);
    rx_ser[ln] = b;
    repeat (15) @(negedge ref_clk);
  endtask
  task automatic send(input logic [3:0] ln, input logic [15:0] lpr,
                      input logic [7:0] d, input logic p, input logic s);
    bitout(ln, 1'b0);
    for (int i = 0; i < 5 + lpr[1:0]; i++) bitout(ln, d[i]);
    if (lpr[4]) bitout(ln, p);
    bitout(ln, s);
    bitout(ln, 1'b1);
    repeat (40) @(negedge ref_clk);
  endtask
  task automatic dma(input logic [21:0] a, input logic e);
    @(negedge ref_clk);
    dma_req = 1'b1;
    dma_req_addr = a;
    for (int i = 0; i < 50 && dma_ack !== 1'b1; i++) @(negedge ref_clk);
    v = dma_rdata;
    dma_req = 1'b0;
    chk({6'h00, v}, {6'h00, a[16:1] ^ 16'hC3A5});
    chk({21'h0, nonexistent_memory_error}, {21'h0, e});
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Self-test plus the nine frames sent fit well inside this span
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("watchdog expired");
    results;
  end
  initial
  begin
    {rst_b, bus_init, reg_rd, reg_wr, dma_req} = 5'b0_0000;
    {pwr_good, sw, reg_addr, wdata} = {1'b1, 24'h00_0000};
    {rx_ser, tx_active, dma_req_addr} = {16'hFFFF, 16'h0000, 22'h00_0000};
    ticks = 16'hFFFF;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 3000 && st_busy !== 1'b0; i++) @(negedge ref_clk);
    chk({21'h0, dma_word}, 22'h1);
    rdchk(OFS_SSR, 16'h0000);
    rdchk(OFS_LPR, LPR_RESET);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(OFS_SCR, {12'h000, rows[i].line});
      wr(OFS_LPR, rows[i].lpr);
      send(rows[i].line, rows[i].lpr, rows[i].data, rows[i].par,
           rows[i].stop);
      rdchk(OFS_SSR, 16'h0100);
      rdchk(OFS_RCR, rows[i].exp);
      rdchk(OFS_RCR, 16'h0000);
    end
    $display("table test done");
    wr(OFS_SCR, 16'h0080);
    wr(OFS_SSR, 16'hFF02);
    send(4'h0, 16'h0003, 8'h31, 1'b0, 1'b1);
    chk({21'h0, irq}, 22'h0);
    send(4'h0, 16'h0003, 8'h32, 1'b0, 1'b1);
    chk({21'h0, irq}, 22'h1);
    rdchk(OFS_SSR, 16'h0202);
    rdchk(OFS_RCR, 16'h8031);
    rdchk(OFS_RCR, 16'h8032);
    repeat (2) @(negedge ref_clk);
    chk({21'h0, irq}, 22'h0);
    $display("threshold test done");
    rx_ser[5] = 1'b0;
    repeat (4) @(negedge ref_clk);
    rx_ser[5] = 1'b1;
    // Long enough for a wrongly accepted frame to reach the silo
    repeat (200) @(negedge ref_clk);
    rdchk(OFS_SSR, 16'h0002);
    ticks[4] = 1'b0;
    send(4'h4, 16'h0003, 8'h77, 1'b0, 1'b1);
    ticks[4] = 1'b1;
    rdchk(OFS_SSR, 16'h0002);
    // No frame is received on the half-duplex line while its transmitter is active
    wr(OFS_SCR, 16'h0002);
    wr(OFS_LPR, 16'h4003);
    tx_active[2] = 1'b1;
    send(4'h2, 16'h4003, 8'h5A, 1'b0, 1'b1);
    rdchk(OFS_SSR, 16'h0002);
    tx_active[2] = 1'b0;
    send(4'h2, 16'h4003, 8'h5A, 1'b0, 1'b1);
    rdchk(OFS_RCR, 16'h825A);
    $display("line test done");
    dma(22'h00_0209, 1'b0);
    dma(22'h00_0214, 1'b1);
    rdchk(OFS_SCR, 16'h0802);
    wr(OFS_SCR, 16'h0002);
    rdchk(OFS_SCR, 16'h0002);
    $display("dma test done");
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_SSR, 16'h0005);
      bus_init = (k == 0);
      pwr_good = (k != 1);
      if (k == 2) wr(OFS_SCR, 16'h1000);
      @(negedge ref_clk);
      {bus_init, pwr_good} = 2'b01;
      rdchk(OFS_SSR, 16'h0000);
      chk({21'h0, st_busy}, 22'h0);
    end
    sw = 4'hF;
    repeat (2) @(negedge ref_clk);
    chk(mux_base, 22'h3F_E0C0);
    chk(modem_base, 22'h3F_F198);
    $display("clear and switch test done");
    results;
  end
endmodule // amr_receive_path_tb

bind amr_receive_path amr_receive_path_assertions
  amr_receive_path_assertions_inst (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .DC_POWER_GOOD(DC_POWER_GOOD), .BUS_INIT(BUS_INIT),
  .BASE_ADDRESS_SWITCH(BASE_ADDRESS_SWITCH), .TX_DMA_ADDR(TX_DMA_ADDR),
  .DMA_DONE(DMA_DONE), .DMA_DATA(DMA_DATA), .IRQ_BR5(IRQ_BR5),
  .NONEXISTENT_MEMORY_ERROR(NONEXISTENT_MEMORY_ERROR),
  .SELF_TEST_BUSY(SELF_TEST_BUSY), .MUX_BASE_ADDR(MUX_BASE_ADDR),
  .MODEM_BASE_ADDR(MODEM_BASE_ADDR), .DMA_RD_STB(DMA_RD_STB),
  .DMA_WORD(DMA_WORD), .DMA_ADDR(DMA_ADDR), .TX_DMA_ACK(TX_DMA_ACK),
  .TX_DMA_DATA(TX_DMA_DATA));
